// ---- hw/icn_defs.vh ----
// constants and register map of the input change notifier
// Overview of operation
// [R1] each line has its own rising-edge enable and its own falling-edge enable
// [R2] an enabled transition on any line raises the change interrupt
// [R3] one shared notification; no record of which line or direction
// [R4] software reads the input port after a notification to get line states
// [R5] a line with both edge enables clear never causes a notification
// [R6] twenty-four input lines are monitored
// [R7] filtered lines drop pulses shorter than the filter interval before detection; the code is sure to drop only pulses up to half the interval
// [R8] one shared interval of 1 to 100 ms; filtering enabled per line
// [R9] inputs sampled every 100 ns; filter clock period is half the interval
// [R10] new level accepted only when steady over two consecutive filter clock edges
// [R11] interrupt stays asserted until software clears it; no extra notifications meanwhile
`ifndef ICN_DEFS_VH
`define ICN_DEFS_VH
`define ICN_LINES        24
`define ICN_ADDR_INPUT   8'h00
`define ICN_ADDR_RISE    8'h04
`define ICN_ADDR_FALL    8'h08
`define ICN_ADDR_FILT    8'h0C
`define ICN_ADDR_IVAL    8'h10
`define ICN_ADDR_STAT    8'h14
`define ICN_STAT_PEND    0
`define ICN_IVAL_W       7
`define ICN_IVAL_MIN     7'h01
`define ICN_IVAL_MAX     7'h64
`define ICN_IVAL_RST     7'h01
`define ICN_SAMPLE_NS    100
`define ICN_HALF_MS_NS   500000
`define ICN_HALF_MS_CYC  (`ICN_HALF_MS_NS / `ICN_SAMPLE_NS)
`define ICN_HTRANS_NSEQ  2'h2
`endif

// ---- hw/icn_filt.v ----
// shared-interval glitch filter for all input lines
`timescale 1ns/1ps
`default_nettype none
module icn_filt #(
    parameter W = 24
) (
    input  wire         clk_i,
    input  wire         rst_n_i,
    input  wire         ce_i,
    input  wire         tick_i,
    input  wire [W-1:0] en_i,
    input  wire [W-1:0] smp_i,
    output wire [W-1:0] lvl_o
);
    reg [W-1:0] held_r;
    reg [W-1:0] steady_r;
    reg [W-1:0] lvl_r;

    assign lvl_o = lvl_r;

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_line
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    held_r[g]   <= 1'b0;
                    steady_r[g] <= 1'b0;
                    lvl_r[g]    <= 1'b0;
                end else if (ce_i) begin
                    if (!en_i[g]) begin
                        // unfiltered lines follow the sample directly
                        lvl_r[g]    <= smp_i[g];
                        held_r[g]   <= smp_i[g];
                        steady_r[g] <= 1'b0;
                    end else if (tick_i) begin
                        if (steady_r[g] && smp_i[g] == held_r[g]) begin
                            lvl_r[g] <= held_r[g]; // R10 R7
                        end
                        held_r[g]   <= smp_i[g];
                        steady_r[g] <= 1'b1;
                    end else if (smp_i[g] != held_r[g]) begin
                        // any change between filter edges voids this window
                        steady_r[g] <= 1'b0; // R9
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ---- hw/icn_top.v ----
// input change notifier: sync, filter, edge detect and AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "icn_defs.vh"
module icn_top #(
    parameter LINES       = `ICN_LINES,
    parameter HALF_MS_CYC = `ICN_HALF_MS_CYC,
    parameter CNT_W       = 20
) (
    input  wire             CLK_SYS_I,
    input  wire             RST_N_I,
    input  wire             CE_I,
    input  wire [LINES-1:0] DIN_I,
    input  wire             HSEL_I,
    input  wire [31:0]      HADDR_I,
    input  wire [1:0]       HTRANS_I,
    input  wire             HWRITE_I,
    input  wire [2:0]       HSIZE_I,
    input  wire [31:0]      HWDATA_I,
    input  wire             HREADY_I,
    output wire [31:0]      HRDATA_O,
    output wire             HREADYOUT_O,
    output wire             HRESP_O,
    output wire             CHG_IRQ_O
);
    reg  [LINES-1:0]        sync1_r;
    reg  [LINES-1:0]        sync2_r;
    reg  [LINES-1:0]        prev_r;
    reg  [LINES-1:0]        rise_en_r;
    reg  [LINES-1:0]        fall_en_r;
    reg  [LINES-1:0]        filt_en_r;
    reg  [`ICN_IVAL_W-1:0]  ival_r;
    reg  [`ICN_IVAL_W-1:0]  half_cnt_r;
    reg  [CNT_W-1:0]        pre_cnt_r;
    reg                     tick_r;
    reg                     pend_r;
    reg                     wr_pend_r;
    reg                     rd_pend_r;
    reg  [7:0]              addr_r;
    reg  [31:0]             hrdata_r;
    reg                     hready_r;
    reg                     hresp_r;
    wire [LINES-1:0]        lvl;
    wire [LINES-1:0]        rise_hit;
    wire [LINES-1:0]        fall_hit;
    wire                    any_hit;
    wire                    acc;
    wire                    pre_wrap;
    wire                    clr_pend;
    wire [`ICN_IVAL_W-1:0]  wr_ival;

    localparam [31:0]      PRE_LAST_W = HALF_MS_CYC - 1;
    localparam [CNT_W-1:0] PRE_LAST   = PRE_LAST_W[CNT_W-1:0];

    assign HRDATA_O    = hrdata_r;
    assign HREADYOUT_O = hready_r;
    assign HRESP_O     = hresp_r;
    assign CHG_IRQ_O   = pend_r;

    // pins come from an isolated domain: two flops before use
    always @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            sync1_r <= {LINES{1'b0}};
            sync2_r <= {LINES{1'b0}};
        end else if (CE_I) begin
            sync1_r <= DIN_I; // R6 R9
            sync2_r <= sync1_r;
        end
    end

    // filter clock: half-millisecond prescaler, then interval count of halves
    // a shared prescaler keeps the interval counter seven bits wide up to 100 ms
    assign pre_wrap = (pre_cnt_r == PRE_LAST);

    always @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pre_cnt_r  <= {CNT_W{1'b0}};
            half_cnt_r <= {`ICN_IVAL_W{1'b0}};
            tick_r     <= 1'b0;
        end else if (CE_I) begin
            tick_r <= 1'b0;
            if (pre_wrap) begin
                pre_cnt_r <= {CNT_W{1'b0}};
                // an interval shortened below the count wraps at once
                if (half_cnt_r + 7'h01 >= ival_r) begin
                    half_cnt_r <= {`ICN_IVAL_W{1'b0}};
                    tick_r     <= 1'b1; // R8 R9
                end else begin
                    half_cnt_r <= half_cnt_r + 7'h01;
                end
            end else begin
                pre_cnt_r <= pre_cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    icn_filt #(
        .W (LINES)
    ) u_filt (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (RST_N_I),
        .ce_i    (CE_I),
        .tick_i  (tick_r),
        .en_i    (filt_en_r),
        .smp_i   (sync2_r),
        .lvl_o   (lvl)
    );

    // edge detection on the filtered levels
    assign rise_hit = lvl & ~prev_r & rise_en_r; // R1 R5
    assign fall_hit = ~lvl & prev_r & fall_en_r; // R1 R5
    assign any_hit  = |(rise_hit | fall_hit);    // R3

    // switching a line's filter off lets its level jump, which may count as an edge
    always @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            prev_r <= {LINES{1'b0}};
        end else if (CE_I) begin
            prev_r <= lvl;
        end
    end

    // bus slave: writes with no wait, reads with one wait state so that a
    // read right after a write always sees the new value
    // size is not decoded: every transfer is treated as a whole word
    assign acc      = HSEL_I && HREADY_I && HTRANS_I == `ICN_HTRANS_NSEQ;
    assign clr_pend = wr_pend_r && addr_r == `ICN_ADDR_STAT && HWDATA_I[`ICN_STAT_PEND];
    assign wr_ival  = HWDATA_I[`ICN_IVAL_W-1:0];

    // unmapped words read as zero and ignore writes
    function [31:0] rd_mux;
        input [7:0] a;
        begin
            case (a)
                `ICN_ADDR_INPUT: rd_mux = {{(32-LINES){1'b0}}, lvl}; // R4
                `ICN_ADDR_RISE:  rd_mux = {{(32-LINES){1'b0}}, rise_en_r};
                `ICN_ADDR_FALL:  rd_mux = {{(32-LINES){1'b0}}, fall_en_r};
                `ICN_ADDR_FILT:  rd_mux = {{(32-LINES){1'b0}}, filt_en_r};
                `ICN_ADDR_IVAL:  rd_mux = {25'h0000000, ival_r};
                `ICN_ADDR_STAT:  rd_mux = {31'h00000000, pend_r};
                default:         rd_mux = 32'h00000000;
            endcase
        end
    endfunction

    always @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h00;
            hrdata_r  <= 32'h00000000;
            hready_r  <= 1'b1;
        end else if (CE_I) begin
            if (rd_pend_r) begin
                hrdata_r  <= rd_mux(addr_r);
                hready_r  <= 1'b1;
                rd_pend_r <= 1'b0;
            end else if (acc) begin
                addr_r    <= {HADDR_I[7:2], 2'b00};
                wr_pend_r <= HWRITE_I;
                rd_pend_r <= ~HWRITE_I;
                hready_r  <= HWRITE_I;
            end else begin
                wr_pend_r <= 1'b0;
            end
            if (rd_pend_r) begin
                wr_pend_r <= 1'b0;
            end
        end
    end

    // register writes land in the data phase
    always @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rise_en_r <= {LINES{1'b0}};
            fall_en_r <= {LINES{1'b0}};
            filt_en_r <= {LINES{1'b0}};
            ival_r    <= `ICN_IVAL_RST;
        end else if (CE_I && wr_pend_r) begin
            case (addr_r)
                `ICN_ADDR_RISE: rise_en_r <= HWDATA_I[LINES-1:0]; // R1
                `ICN_ADDR_FALL: fall_en_r <= HWDATA_I[LINES-1:0]; // R1
                `ICN_ADDR_FILT: filt_en_r <= HWDATA_I[LINES-1:0]; // R8
                `ICN_ADDR_IVAL: begin
                    // out-of-range intervals are clamped, not refused
                    if (wr_ival < `ICN_IVAL_MIN) begin
                        ival_r <= `ICN_IVAL_MIN; // R8
                    end else if (wr_ival > `ICN_IVAL_MAX) begin
                        ival_r <= `ICN_IVAL_MAX; // R8
                    end else begin
                        ival_r <= wr_ival;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // one sticky notification; a new change in the clear cycle wins
    always @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pend_r <= 1'b0;
        end else if (CE_I) begin
            if (any_hit) begin
                pend_r <= 1'b1; // R2 R11
            end else if (clr_pend) begin
                pend_r <= 1'b0; // R11
            end
        end
    end

    // every transfer ends OKAY; the flop keeps the port registered like the others
    always @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            hresp_r <= 1'b0;
        end else if (CE_I) begin
            hresp_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- tb/icn_monitor.sv ----
// port assertions for the input change notifier
`timescale 1ns/1ps
`default_nettype none
module icn_monitor (
    input wire logic        CLK_SYS_I,
    input wire logic        RST_N_I,
    input wire logic        CE_I,
    input wire logic        HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0]  HTRANS_I,
    input wire logic        HWRITE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic        HREADY_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic        HREADYOUT_O,
    input wire logic        HRESP_O,
    input wire logic        CHG_IRQ_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RST_N_I);
    wire logic tk = CE_I && HSEL_I && HREADY_I && HTRANS_I == 2'h2;
    wire logic rd = tk && !HWRITE_I;
    wire logic wst = tk && HWRITE_I && HADDR_I[7:2] == 6'h05;
    sequence s_rd_ans;
        !HREADYOUT_O ##1 HREADYOUT_O;
    endsequence
    AST_RD_WAIT: assert property (rd |=> s_rd_ans) else $error("read wait wrong");
    AST_WR_NOWAIT: assert property (tk && HWRITE_I |=> HREADYOUT_O) else $error("write stalled");
    AST_OKAY: assert property (HRESP_O == 1'b0) else $error("response not okay");
    AST_HOLD: assert property (HREADYOUT_O && $past(HREADYOUT_O) |-> $stable(HRDATA_O)) else $error("rdata moved");
    AST_STICKY: assert property (CHG_IRQ_O && !($past(wst) && HWDATA_I[0]) |=> CHG_IRQ_O) else $error("irq dropped");
    AST_STAT_RD: assert property (rd && HADDR_I[7:2] == 6'h05 |=> ##1 HRDATA_O == {31'h0, $past(CHG_IRQ_O)})
        else $error("status read wrong");
    AST_UNMAPPED: assert property (rd && HADDR_I[7:2] > 6'h05 |=> ##1 HRDATA_O == 32'h0) else $error("unmapped read");
    AST_FREEZE: assert property (!CE_I |=> $stable(CHG_IRQ_O) && $stable(HREADYOUT_O)) else $error("not frozen");
endmodule
bind icn_top icn_monitor icn_monitor_i (.CLK_SYS_I(CLK_SYS_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .HSEL_I(HSEL_I),
    .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I),
    .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .CHG_IRQ_O(CHG_IRQ_O));
`default_nettype wire

// ---- tb/icn_host.sv ----
// host model: counts change notifications on the interrupt line
`timescale 1ns/1ps
`default_nettype none
module icn_host (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic irq_i,
    output var  int   n_note_o
);
    logic irq_r;
    // a level stays up while pending, so only its rising edge is a new notification
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_r <= 1'b0;
            n_note_o <= 0;
        end else begin
            irq_r <= irq_i;
            if (irq_i && !irq_r)
                n_note_o <= n_note_o + 1;
        end
    end
endmodule
`default_nettype wire

// ---- tb/input_change_notifier_bench.sv ----
// self-checking bench for the input change notifier
`timescale 1ns/1ps
`default_nettype none
`include "icn_defs.vh"
module input_change_notifier_bench;
    logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [23:0] din = 24'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, v;
    logic [1:0]  htrans = 2'h0;
    logic        hready, hresp, irq;
    int          n_mismatch = 0, checks = 0, cyc = 0, notes, ln, m, seed = 32'hF8580602;
    logic [31:0] iv [4] = '{32'h0, 32'h32, 32'h65, 32'h7F};
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch = n_mismatch + 1;
            complete_run();
        end
    end
    icn_top #(.HALF_MS_CYC(4)) icn_top_i (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CE_I(ce), .DIN_I(din), .HSEL_I(hsel),
        .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .CHG_IRQ_O(irq));
    icn_host icn_host_i (.clk_i(clk), .rst_n_i(rst_n), .irq_i(irq), .n_note_o(notes));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // entered just after a rising edge; the address phase is held until hready is sampled high
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= `ICN_HTRANS_NSEQ;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    function automatic logic [31:0] exp_ival(input logic [31:0] x);
        return (x[6:0] < 7'h01) ? 32'h1 : (x[6:0] > 7'h64) ? 32'h64 : {25'h0, x[6:0]};
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 32; a += 4) begin
            bus(1'b0, a[7:0], 32'h0);
            chk("reset value", {31'h0, a == 16}, q);
            chk("response", 32'h0, {31'h0, hresp});
        end
        for (int i = 1; i < 4; i++) begin
            v = $random(seed);
            bus(1'b1, 8'(4 * i), v);
            bus(1'b0, 8'(4 * i), 32'h0);
            chk("enable readback", {8'h0, v[23:0]}, q);
        end
        foreach (iv[i]) begin
            bus(1'b1, `ICN_ADDR_IVAL, iv[i]);
            bus(1'b0, `ICN_ADDR_IVAL, 32'h0);
            chk("interval", exp_ival(iv[i]), q);
        end
        bus(1'b1, 8'h20, 32'hFFFFFFFF);
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, q);
        bus(1'b1, `ICN_ADDR_FILT, 32'h0);
        // other lines toggle at random with their enables clear; only the chosen line may notify
        for (m = 0; m < 4; m++) begin
            ln = {$random(seed)} % 24;
            v = din;
            v[ln] = 1'b0;
            din <= v[23:0];
            bus(1'b1, `ICN_ADDR_RISE, (m & 1) << ln);
            bus(1'b1, `ICN_ADDR_FALL, (m >> 1) << ln);
            for (int r = 1; r >= 0; r--) begin
                bus(1'b1, `ICN_ADDR_STAT, 32'h1);
                v = $random(seed);
                v[ln] = r[0];
                din <= v[23:0];
                repeat (4) @(posedge clk);
                chk("irq early", 32'h0, {31'h0, irq});
                @(posedge clk);
                chk("irq", (r == 1) ? (m & 1) : (m >> 1), {31'h0, irq});
                bus(1'b0, `ICN_ADDR_INPUT, 32'h0);
                chk("input port", {8'h0, din}, q);
            end
        end
        bus(1'b1, `ICN_ADDR_IVAL, 32'h1);
        bus(1'b1, `ICN_ADDR_RISE, 32'hFFFFFF);
        bus(1'b1, `ICN_ADDR_FALL, 32'h0);
        din <= 24'h0;
        bus(1'b1, `ICN_ADDR_FILT, 32'hFFFFFF);
        repeat (20) @(posedge clk);
        bus(1'b1, `ICN_ADDR_STAT, 32'h1);
        m = notes;
        din <= 24'h1;
        repeat (2) @(posedge clk);
        din <= 24'h0;
        repeat (12) @(posedge clk);
        chk("glitch", 32'h0, {31'h0, irq});
        din <= 24'h1;
        repeat (5) @(posedge clk);
        chk("filter early", 32'h0, {31'h0, irq});
        repeat (9) @(posedge clk);
        chk("filter pass", 32'h1, {31'h0, irq});
        chk("notes", 32'h1, notes - m);
        ce <= 1'b0;
        repeat (5) @(posedge clk);
        ce <= 1'b1;
        bus(1'b0, `ICN_ADDR_STAT, 32'h0);
        chk("status", 32'h1, q);
        // a two-millisecond interval doubles the filter clock period to eight cycles
        bus(1'b1, `ICN_ADDR_IVAL, 32'h2);
        din <= 24'h0;
        repeat (30) @(posedge clk);
        bus(1'b1, `ICN_ADDR_STAT, 32'h1);
        @(posedge clk);
        chk("clear", 32'h0, {31'h0, irq});
        din <= 24'h1;
        repeat (9) @(posedge clk);
        chk("slow filter early", 32'h0, {31'h0, irq});
        repeat (12) @(posedge clk);
        chk("slow filter pass", 32'h1, {31'h0, irq});
        complete_run();
    end
endmodule
`default_nettype wire
